// [hdl/rf_guard.sv]
// Purpose: Role selection and initial RF collision check for a P2P end.
// Assumes: Strength code and external field flag arrive from the analog
//   front end as asynchronous levels; host commands are SYS_CLK pulses.
// Notes: The own field is only ever switched on from the decide state.
`timescale 1ns/1ps
module rf_guard
#(
  parameter int SETTLE_CYCLES = rf_guard_pkg::SETTLE_CYC
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Host configuration
  input wire logic POLL_START,
  input wire logic ACTIVE_MODE,
  input wire logic [1:0] RATE_SEL,
  input wire logic TX_ENABLE,
  input wire logic RX_ENABLE,
  input wire logic [31:0] HOLD_CYCLES,
  // Host commands
  input wire logic MEASURE_CMD,
  // Analog front end
  input wire logic [2:0] EXT_STRENGTH,
  input wire logic EXT_FIELD_ON,
  // Status and field control
  output logic [2:0] STRENGTH,
  output logic STRENGTH_VALID,
  output logic BUSY,
  output logic INITIATOR,
  output logic IN_HOLD,
  output logic RATE_OK,
  output logic FIELD_ON,
  output logic LOAD_MOD_EN
);

  // ***************************************************************
  // Pin synchronisation
  // ***************************************************************
  logic [3:0] pins_s;
  rf_sync2 #(.W(4)) u_sync
  (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din({EXT_FIELD_ON, EXT_STRENGTH}),
    .dout(pins_s)
  );
  wire [2:0] strength_s = pins_s[2:0];
  wire ext_on_s = pins_s[3];

  // ***************************************************************
  // State and registers
  // ***************************************************************
  rf_guard_pkg::guard_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [2:0] strength_q;
  logic valid_q;
  logic init_q;
  logic field_q, field_d;
  logic [1:0] rate_q;
  logic active_q;

  // Rates outside the three permitted ones never allow the field on.
  wire rate_legal = (RATE_SEL == rf_guard_pkg::RATE_106) ||
                    (RATE_SEL == rf_guard_pkg::RATE_212) ||
                    (RATE_SEL == rf_guard_pkg::RATE_424);
  // The check is only honoured with transmitter off and receiver on.
  wire prep_ok = !TX_ENABLE && RX_ENABLE;
  wire start = MEASURE_CMD && prep_ok && rate_legal;
  wire settle_done = (cnt_q == 32'(SETTLE_CYCLES - 1));
  wire hold_done = (cnt_q >= HOLD_CYCLES);
  wire clear_air = (strength_q == 3'h0) && !ext_on_s;
  // An active target may only drive while the initiator field is absent.
  wire target_ok = active_q && !ext_on_s;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    field_d = field_q;
    case (state_q)
      rf_guard_pkg::ST_IDLE:
      begin
        if (start)
        begin
          state_d = rf_guard_pkg::ST_MEASURE;
          cnt_d = 32'h0;
          field_d = 1'b0;
        end
      end
      rf_guard_pkg::ST_MEASURE:
      begin
        cnt_d = cnt_q + 32'h1;
        if (settle_done)
        begin
          state_d = rf_guard_pkg::ST_DECIDE;
        end
      end
      rf_guard_pkg::ST_DECIDE:
      begin
        cnt_d = 32'h0;
        if (!clear_air)
        begin
          state_d = rf_guard_pkg::ST_HOLD;
        end
        else if (init_q || target_ok)
        begin
          state_d = rf_guard_pkg::ST_FIELD;
          field_d = 1'b1;
        end
        else
        begin
          state_d = rf_guard_pkg::ST_IDLE;
        end
      end
      rf_guard_pkg::ST_FIELD:
      begin
        // Target drops its field as soon as the initiator's appears.
        if (MEASURE_CMD || (!init_q && ext_on_s))
        begin
          state_d = rf_guard_pkg::ST_IDLE;
          field_d = 1'b0;
        end
      end
      rf_guard_pkg::ST_HOLD:
      begin
        cnt_d = cnt_q + 32'h1;
        if (hold_done)
        begin
          // Expiry rechecks the air; it never enables the field directly.
          state_d = rf_guard_pkg::ST_MEASURE;
          cnt_d = 32'h0;
        end
      end
      default:
      begin
        state_d = rf_guard_pkg::ST_IDLE;
        field_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_q <= rf_guard_pkg::ST_IDLE;
      cnt_q <= 32'h0;
      field_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      field_q <= field_d;
    end
  end

  // Role and mode are taken when a check starts so they stay stable.
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      init_q <= 1'b0;
      active_q <= 1'b0;
    end
    else if (start && state_q == rf_guard_pkg::ST_IDLE)
    begin
      init_q <= POLL_START;
      active_q <= ACTIVE_MODE;
    end
  end

  // Every command seen in idle records its rate, so a refused rate shows.
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rate_q <= 2'h0;
    end
    else if (MEASURE_CMD && state_q == rf_guard_pkg::ST_IDLE)
    begin
      rate_q <= RATE_SEL;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      strength_q <= 3'h0;
      valid_q <= 1'b0;
    end
    else if (state_q == rf_guard_pkg::ST_MEASURE && settle_done)
    begin
      strength_q <= strength_s;
      valid_q <= 1'b1;
    end
    else if (start && state_q == rf_guard_pkg::ST_IDLE)
    begin
      valid_q <= 1'b0;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign STRENGTH = strength_q;
  assign STRENGTH_VALID = valid_q;
  assign BUSY = (state_q == rf_guard_pkg::ST_MEASURE) ||
                (state_q == rf_guard_pkg::ST_DECIDE);
  assign INITIATOR = init_q;
  assign IN_HOLD = (state_q == rf_guard_pkg::ST_HOLD);
  assign RATE_OK = (rate_q != 2'h3);
  assign FIELD_ON = field_q;
  assign LOAD_MOD_EN = !init_q && !active_q && ext_on_s;

  // ***************************************************************
  // Checks
  // ***************************************************************
  // Age of the measure phase, counted apart from cnt_q so that a fault in
  // the settle counter cannot hide itself from the latch check.
  logic [31:0] meas_age_q;

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      meas_age_q <= 32'h0;
    end
    else if (state_q == rf_guard_pkg::ST_MEASURE)
    begin
      meas_age_q <= meas_age_q + 32'h1;
    end
    else
    begin
      meas_age_q <= 32'h0;
    end
  end

  a_field_needs_quiet: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(field_q) |-> $past(strength_q) == 3'h0)
    else $error("Field enabled with external strength present.");
  a_measure_first: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(field_q) |-> $past(state_q) == rf_guard_pkg::ST_DECIDE)
    else $error("Field enabled without a fresh measurement.");
  a_settle_latch: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == rf_guard_pkg::ST_MEASURE) |->
      (meas_age_q < 32'(SETTLE_CYCLES)))
    else $error("Strength not latched within settling delay.");
  a_decide_latched: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == rf_guard_pkg::ST_DECIDE) |-> valid_q)
    else $error("Decision taken before the strength was latched.");
  a_hold_recheck: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == rf_guard_pkg::ST_HOLD && hold_done) |=>
      state_q == rf_guard_pkg::ST_MEASURE)
    else $error("Hold expiry did not repeat the check.");
  a_passive_no_field: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (!init_q && !active_q) |-> !$rose(field_q))
    else $error("Passive target drove its own field.");
  a_target_yields: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (field_q && !init_q && ext_on_s) |=> !field_q)
    else $error("Active target kept field with initiator present.");
  a_hold_nonzero: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == rf_guard_pkg::ST_DECIDE && strength_q != 3'h0) |=>
      (state_q == rf_guard_pkg::ST_HOLD && !field_q))
    else $error("Nonzero strength did not enter hold.");
  a_initiator_field: assert property (
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == rf_guard_pkg::ST_DECIDE && init_q && clear_air) |=>
      field_q)
    else $error("Initiator failed to raise the carrier.");

endmodule

// [hdl/rf_guard_pkg.sv]
// Purpose: Constants for the peer-to-peer RF role and field guard.
// Assumes: One clock at 250 MHz, asynchronous active-high reset.
// Notes: Behaviour list follows; each item is kept by the guard logic.
//
// Behaviour
// - Exchange uses type A at 106 kbps or type F at 212 or 424 kbps.
// - A poller at start becomes initiator; a listener becomes target.
// - As initiator the device drives the carrier in active and passive modes.
// - Active target drives its field only while the initiator field is off.
// - As passive target the field stays off; answers by load modulation.
// - External subcarrier strength is measured before own field goes on.
// - A measured external strength above zero keeps the own field disabled.
// - External strength is a 3-bit code; its meaning depends on antenna.
// - Host issues measure command; device then measures the field strength.
// - Strength is latched within the settle delay; host waits to read.
package rf_guard_pkg;

  // ***************************************************************
  // Rates and widths
  // ***************************************************************
  localparam int STRENGTH_W = 3;
  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] RATE_212 = 2'h1;
  localparam logic [1:0] RATE_424 = 2'h2;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_US = 50;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int HOLD_W = 32;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_MEASURE = 3'h1,
    ST_DECIDE = 3'h3,
    ST_FIELD = 3'h2,
    ST_HOLD = 3'h6
  } guard_state_t;

endpackage

// [hdl/rf_sync2.sv]
// Purpose: Two-stage synchroniser for a bus of pin levels.
// Assumes: Inputs are asynchronous to SYS_CLK.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module rf_sync2
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

// [sim/rf_guard_bench.sv]
// Purpose: Self-checking bench for the RF role and field guard.
// Assumes: Short settle and hold counts keep the run brief.
// Notes: Inputs change on the falling edge only.
`timescale 1ns/1ps
module rf_guard_bench;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clk = 1'b0, rst = 1'b1, poll = 1'b0, act = 1'b0;
  logic tx = 1'b0, rx = 1'b1, meas = 1'b0;
  logic present = 1'b0, carrier = 1'b0;
  logic [1:0] rate = 2'h0;
  logic [2:0] level = 3'h0;
  logic [31:0] hold = 32'h5;
  logic [2:0] ext_s, strength;
  logic ext_f, valid, busy, init, in_hold, rate_ok, field, lmod;
  int err_total = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  rf_peer_model rf_peer_model_i (.present(present), .level(level),
    .carrier(carrier), .ext_strength(ext_s), .ext_field(ext_f));
  rf_guard #(.SETTLE_CYCLES(20)) rf_guard_i (.SYS_CLK(clk), .SYS_RST(rst),
    .POLL_START(poll), .ACTIVE_MODE(act), .RATE_SEL(rate),
    .TX_ENABLE(tx), .RX_ENABLE(rx), .HOLD_CYCLES(hold),
    .MEASURE_CMD(meas), .EXT_STRENGTH(ext_s), .EXT_FIELD_ON(ext_f),
    .STRENGTH(strength), .STRENGTH_VALID(valid), .BUSY(busy),
    .INITIATOR(init), .IN_HOLD(in_hold), .RATE_OK(rate_ok),
    .FIELD_ON(field), .LOAD_MOD_EN(lmod));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic pulse;
    @(negedge clk) meas = 1'b1;
    @(negedge clk) meas = 1'b0;
    @(negedge clk);
  endtask
  // Starts a check and stops one cycle after the latch, once the decision has taken effect.
  task automatic run_check;
    int i;
    pulse();
    chk(busy, 1'b1);
    for (i = 0; i < 200 && valid !== 1'b1; i++) @(negedge clk);
    if (valid !== 1'b1)
    begin
      err_total++;
      print_verdict();
    end
    @(negedge clk);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    chk({field, strength, valid, init, busy}, 7'h00);
    chk({in_hold, rate_ok, lmod}, 3'h2);
    $display("reset test done");
  endtask
  task automatic t_initiator;
    poll = 1'b1;
    rate = 2'h2;
    run_check();
    chk(strength, 3'h0);
    chk(init, 1'b1);
    chk(field, 1'b1);
    chk(rate_ok, 1'b1);
    pulse();
    chk(field, 1'b0);
    $display("initiator test done");
  endtask
  task automatic t_collision;
    int i;
    present = 1'b1;
    level = 3'h5;
    run_check();
    chk(strength, 3'h5);
    chk(field, 1'b0);
    chk(in_hold, 1'b1);
    level = 3'h0;
    for (i = 0; i < 200 && field !== 1'b1; i++) @(negedge clk);
    chk(field, 1'b1);
    chk(i >= 25, 1'b1);
    pulse();
    $display("collision test done");
  endtask
  // A sensed carrier sends the target into hold; the recheck then raises it.
  task automatic t_active_target;
    int i;
    poll = 1'b0;
    act = 1'b1;
    carrier = 1'b1;
    run_check();
    chk({init, field, in_hold}, 3'h1);
    carrier = 1'b0;
    for (i = 0; i < 200 && field !== 1'b1; i++) @(negedge clk);
    chk(field, 1'b1);
    carrier = 1'b1;
    repeat (4) @(negedge clk);
    chk(field, 1'b0);
    $display("active target test done");
  endtask
  task automatic t_passive;
    int i;
    act = 1'b0;
    run_check();
    chk(field, 1'b0);
    chk(lmod, 1'b1);
    carrier = 1'b0;
    repeat (4) @(negedge clk);
    chk(lmod, 1'b0);
    for (i = 0; i < 200 && (busy !== 1'b0 || in_hold !== 1'b0); i++)
      @(negedge clk);
    chk({busy, in_hold, field}, 3'h0);
    $display("passive target test done");
  endtask
  task automatic t_refuse;
    present = 1'b0;
    tx = 1'b1;
    pulse();
    chk(busy, 1'b0);
    tx = 1'b0;
    rx = 1'b0;
    pulse();
    chk(busy, 1'b0);
    rx = 1'b1;
    rate = 2'h3;
    pulse();
    chk({busy, rate_ok}, 2'h0);
    rate = 2'h1;
    run_check();
    chk(rate_ok, 1'b1);
    $display("refusal test done");
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_reset();
    t_initiator();
    t_collision();
    t_active_target();
    t_passive();
    t_refuse();
    print_verdict();
  end
endmodule

// [sim/rf_peer_model.sv]
// Purpose: Remote peer as seen through the front end of the guard.
// Assumes: The bench sets presence, subcarrier code and carrier state.
// Notes: Outputs move off the clock grid, as real air-side levels do.
`timescale 1ns/1ps
module rf_peer_model
(
  // Bench control
  input wire logic present,
  input wire logic [2:0] level,
  input wire logic carrier,
  // Air side
  output logic [2:0] ext_strength,
  output logic ext_field
);
  // An absent peer shows neither subcarrier nor carrier.
  assign #1.3 ext_strength = present ? level : 3'h0;
  assign #1.3 ext_field = present & carrier;
endmodule
